/* inc/liu_bank_pkg.sv */
// Constants, types and helpers shared by the channel configuration bank
package liu_bank_pkg;

	// Channel count and register width
	localparam int CHANNELS = 8;
	localparam int DATA_W   = 8;
	localparam int ADDR_W   = 8;

	// Primary bank offsets
	localparam logic [ADDR_W-1:0] OFF_DRIVER_OUTPUT_ENABLE   = 8'h12;
	localparam logic [ADDR_W-1:0] OFF_ALARM_SIGNAL_STATUS    = 8'h13;
	localparam logic [ADDR_W-1:0] OFF_ALARM_INTERRUPT_MASK   = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_ALARM_INTERRUPT_STATUS = 8'h15;
	localparam logic [ADDR_W-1:0] OFF_BANK_POINTER           = 8'h1f;

	// Expanded bank offsets
	localparam logic [ADDR_W-1:0] OFF_SINGLE_RAIL_FORCE        = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_LINE_CODE_SELECT         = 8'h01;
	localparam logic [ADDR_W-1:0] OFF_RECOVERY_DISABLE         = 8'h02;
	localparam logic [ADDR_W-1:0] OFF_RECEIVER_POWERDOWN       = 8'h03;
	localparam logic [ADDR_W-1:0] OFF_TRANSMITTER_POWERDOWN    = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_ZERO_RUN_DETECT_ENABLE   = 8'h05;
	localparam logic [ADDR_W-1:0] OFF_VIOLATION_DETECT_DISABLE = 8'h06;
	localparam logic [ADDR_W-1:0] OFF_SINGLE_ENDED_TERMINATION = 8'h07;
	localparam logic [ADDR_W-1:0] OFF_INBAND_LOOP_CONFIG       = 8'h08;

	// Pointer values that select a bank
	localparam logic [DATA_W-1:0] PRIMARY_KEY  = 8'h00;
	localparam logic [DATA_W-1:0] EXPANDED_KEY = 8'haa;

	// Value of every register after reset, and of unmapped reads
	localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;

	// Loop configuration field positions
	localparam int LOOP_DET_BIT  = 5;
	localparam int AUTO_LOOP_BIT = 4;
	localparam int ACT_LEN_LSB   = 2;
	localparam int DEACT_LEN_LSB = 0;

	// Transmit clock held-low detection: least time, then cycles at 40 ns
	localparam int CLK_PERIOD_NS     = 40;
	localparam int CLOCK_LOSS_NS     = 2000;
	localparam int CLOCK_LOSS_CYCLES = (CLOCK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOSS_CNT_W        = 6;

	// Which register bank the pointer selects
	typedef enum logic {
		BANK_PRIMARY  = 1'b0,
		BANK_EXPANDED = 1'b1
	} bank_t;

	// Effective upper code bits for a two-bit length field
	function automatic logic [DATA_W-1:0] code_mask(input logic [1:0] len);
		logic [DATA_W-1:0] m;
		m = 8'hf8;
		unique case (len)
			2'b00: m = 8'hf8;
			2'b01: m = 8'hfc;
			2'b10: m = 8'hfe;
			2'b11: m = 8'hff;
		endcase
		return m;
	endfunction

endpackage

/* logic/tx_clock_loss.sv */
// Detects a transmit clock pin that stays low for too long
`timescale 1ns/10ps
`default_nettype none

module tx_clock_loss (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_b,
	// Transmit clock pin, asynchronous to clock
	input  wire logic pin,
	// High while the pin has been low for the whole detection time
	output logic      held_low
);
	import liu_bank_pkg::*;

	logic                  sync1_reg;
	logic                  sync2_reg;
	logic [LOSS_CNT_W-1:0] low_cnt_reg;

	// Two-stage synchroniser
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= pin;
			sync2_reg <= sync1_reg;
		end
	end

	// Counts low cycles, saturating at the limit
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			low_cnt_reg <= '0;
			held_low    <= 1'b0;
		end else if (sync2_reg) begin
			low_cnt_reg <= '0;
			held_low    <= 1'b0;
		end else if (low_cnt_reg != LOSS_CNT_W'(CLOCK_LOSS_CYCLES)) begin
			low_cnt_reg <= low_cnt_reg + 1'b1;
			held_low    <= 1'b0;
		end else begin
			held_low    <= 1'b1;
		end
	end

endmodule

`default_nettype wire

/* logic/liu_channel_config_status_bank.sv */
// Per-channel configuration and alarm status register bank with host port
//
// Overview of operation
// - Output enable bit set puts driver high-Z
// - Alarm status bit reads one while detected
// - Mask bit one allows channel alarm interrupt
// - Any alarm change sets flag when unmasked
// - Reading alarm status clears latched flags
// - Pointer 00 selects primary, AA expanded
// - After reset pointer is zero, primary bank
// - Single rail bit forces single rail, recovery
// - Line code bit picks AMI, gated
// - Recovery bit set disables clock recovery
// - Receiver power-down bit powers receiver down
// - Transmitter off on bit or clock low
// - Zero-run bit enables excessive zero detection
// - Violation bit zero enables violation detection
// - Termination bit selects single-ended tip termination
// - Bit five enables loop code detection
// - Bit four enables automatic inband loopback
// - Activate length field masks upper code bits
// - Deactivate length field uses same mapping
// - Loop config register is global
`timescale 1ns/10ps
`default_nettype none

module liu_channel_config_status_bank (
	// Clock and reset
	input  wire logic                                     clock,
	input  wire logic                                     rst_b,
	// Host parallel port pins
	input  wire logic                                     cs_b,
	input  wire logic                                     rd_b,
	input  wire logic                                     wr_b,
	input  wire logic [liu_bank_pkg::ADDR_W-1:0]          addr,
	input  wire logic [liu_bank_pkg::DATA_W-1:0]          data_in,
	output logic      [liu_bank_pkg::DATA_W-1:0]          data_out,
	output logic                                          data_oe,
	// Channel inputs
	input  wire logic [liu_bank_pkg::CHANNELS-1:0]        alarm_detect,
	input  wire logic [liu_bank_pkg::CHANNELS-1:0]        transmit_clock_pin,
	input  wire logic [liu_bank_pkg::CHANNELS-1:0]        negative_transmit_data_pin,
	// Channel controls
	output logic      [liu_bank_pkg::CHANNELS-1:0]        driver_high_z,
	output logic      [liu_bank_pkg::CHANNELS-1:0]        transmitter_off,
	output logic      [liu_bank_pkg::CHANNELS-1:0]        receiver_off,
	output logic      [liu_bank_pkg::CHANNELS-1:0]        single_rail_mode,
	output logic      [liu_bank_pkg::CHANNELS-1:0]        recovery_on,
	output logic      [liu_bank_pkg::CHANNELS-1:0]        ami_select,
	output logic      [liu_bank_pkg::CHANNELS-1:0]        zero_detect_on,
	output logic      [liu_bank_pkg::CHANNELS-1:0]        violation_detect_on,
	output logic      [liu_bank_pkg::CHANNELS-1:0]        termination_single,
	// Global loopback controls
	output logic                                          loop_detector_enable,
	output logic                                          auto_loop_enable,
	output logic      [liu_bank_pkg::DATA_W-1:0]          activate_code_mask,
	output logic      [liu_bank_pkg::DATA_W-1:0]          deactivate_code_mask
);
	import liu_bank_pkg::*;

	// Host pin synchronisers and strobe history
	logic                rd_s1_reg, rd_s2_reg, rd_d_reg;
	logic                wr_s1_reg, wr_s2_reg, wr_d_reg;
	logic [ADDR_W-1:0]   addr_s1_reg, addr_s2_reg;
	logic [DATA_W-1:0]   din_s1_reg, din_s2_reg;
	logic [CHANNELS-1:0] tdn_s1_reg, tdn_s2_reg;

	// Registers
	logic [DATA_W-1:0] single_rail_force_reg;
	logic [DATA_W-1:0] line_code_select_reg;
	logic [DATA_W-1:0] recovery_disable_reg;
	logic [DATA_W-1:0] receiver_powerdown_reg;
	logic [DATA_W-1:0] transmitter_powerdown_reg;
	logic [DATA_W-1:0] zero_run_detect_enable_reg;
	logic [DATA_W-1:0] violation_detect_disable_reg;
	logic [DATA_W-1:0] single_ended_termination_reg;
	logic [DATA_W-1:0] inband_loop_config_reg;
	logic [DATA_W-1:0] driver_output_enable_reg;
	logic [DATA_W-1:0] alarm_signal_status_reg;
	logic [DATA_W-1:0] alarm_irq_mask_reg;
	logic [DATA_W-1:0] alarm_irq_flags_reg;
	logic [DATA_W-1:0] bank_pointer_reg;

	logic                read_start;
	logic                write_commit;
	bank_t               bank;
	logic [DATA_W-1:0]   read_next;
	logic [CHANNELS-1:0] alarm_edge;
	logic                flag_clear;
	logic [CHANNELS-1:0] clock_lost;
	logic [CHANNELS-1:0] single_next;

	// Host strobes and buses pass two flip-flops before use
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rd_s1_reg   <= 1'b0;
			rd_s2_reg   <= 1'b0;
			rd_d_reg    <= 1'b0;
			wr_s1_reg   <= 1'b0;
			wr_s2_reg   <= 1'b0;
			wr_d_reg    <= 1'b0;
			addr_s1_reg <= '0;
			addr_s2_reg <= '0;
			din_s1_reg  <= '0;
			din_s2_reg  <= '0;
			tdn_s1_reg  <= '0;
			tdn_s2_reg  <= '0;
		end else begin
			rd_s1_reg   <= !cs_b && !rd_b;
			rd_s2_reg   <= rd_s1_reg;
			rd_d_reg    <= rd_s2_reg;
			wr_s1_reg   <= !cs_b && !wr_b;
			wr_s2_reg   <= wr_s1_reg;
			wr_d_reg    <= wr_s2_reg;
			addr_s1_reg <= addr;
			addr_s2_reg <= addr_s1_reg;
			din_s1_reg  <= data_in;
			din_s2_reg  <= din_s1_reg;
			tdn_s1_reg  <= negative_transmit_data_pin;
			tdn_s2_reg  <= tdn_s1_reg;
		end
	end

	// One-cycle access events, bank decode and alarm edges
	assign read_start   = rd_s2_reg && !rd_d_reg;
	assign write_commit = wr_s2_reg && !wr_d_reg;
	assign bank         = (bank_pointer_reg == EXPANDED_KEY) ? BANK_EXPANDED : BANK_PRIMARY;
	assign alarm_edge   = alarm_detect ^ alarm_signal_status_reg;
	assign flag_clear   = read_start && bank == BANK_PRIMARY
	                      && addr_s2_reg == OFF_ALARM_SIGNAL_STATUS;

	// Transmit clock held-low detectors, one per channel
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_loss
			tx_clock_loss u_loss (
				.clock    (clock),
				.rst_b    (rst_b),
				.pin      (transmit_clock_pin[ch]),
				.held_low (clock_lost[ch])
			);
		end
	endgenerate

	// Bank pointer, reachable from either bank
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bank_pointer_reg <= PRIMARY_KEY;
		end else if (write_commit && addr_s2_reg == OFF_BANK_POINTER) begin
			bank_pointer_reg <= din_s2_reg;
		end
	end

	// Primary bank writable registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			driver_output_enable_reg <= RESET_VALUE;
			alarm_irq_mask_reg       <= RESET_VALUE;
		end else if (write_commit && bank == BANK_PRIMARY) begin
			if (addr_s2_reg == OFF_DRIVER_OUTPUT_ENABLE) begin
				driver_output_enable_reg <= din_s2_reg;
			end
			if (addr_s2_reg == OFF_ALARM_INTERRUPT_MASK) begin
				alarm_irq_mask_reg <= din_s2_reg;
			end
		end
	end

	// Expanded bank writable registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			single_rail_force_reg        <= RESET_VALUE;
			line_code_select_reg         <= RESET_VALUE;
			recovery_disable_reg         <= RESET_VALUE;
			receiver_powerdown_reg       <= RESET_VALUE;
			transmitter_powerdown_reg    <= RESET_VALUE;
			zero_run_detect_enable_reg   <= RESET_VALUE;
			violation_detect_disable_reg <= RESET_VALUE;
			single_ended_termination_reg <= RESET_VALUE;
			inband_loop_config_reg       <= RESET_VALUE;
		end else if (write_commit && bank == BANK_EXPANDED) begin
			unique case (addr_s2_reg)
				OFF_SINGLE_RAIL_FORCE:        single_rail_force_reg        <= din_s2_reg;
				OFF_LINE_CODE_SELECT:         line_code_select_reg         <= din_s2_reg;
				OFF_RECOVERY_DISABLE:         recovery_disable_reg         <= din_s2_reg;
				OFF_RECEIVER_POWERDOWN:       receiver_powerdown_reg       <= din_s2_reg;
				OFF_TRANSMITTER_POWERDOWN:    transmitter_powerdown_reg    <= din_s2_reg;
				OFF_ZERO_RUN_DETECT_ENABLE:   zero_run_detect_enable_reg   <= din_s2_reg;
				OFF_VIOLATION_DETECT_DISABLE: violation_detect_disable_reg <= din_s2_reg;
				OFF_SINGLE_ENDED_TERMINATION: single_ended_termination_reg <= din_s2_reg;
				OFF_INBAND_LOOP_CONFIG:       inband_loop_config_reg       <= din_s2_reg;
				default: begin
				end
			endcase
		end
	end

	// Alarm status follows the detectors
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			alarm_signal_status_reg <= RESET_VALUE;
		end else begin
			alarm_signal_status_reg <= alarm_detect;
		end
	end

	// Latched alarm flags: a new edge wins over the read clear
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			alarm_irq_flags_reg <= RESET_VALUE;
		end else begin
			alarm_irq_flags_reg <= (flag_clear ? '0 : alarm_irq_flags_reg)
			                       | (alarm_edge & alarm_irq_mask_reg);
		end
	end

	// Read data multiplexer, zero for unmapped offsets
	always_comb begin
		read_next = RESET_VALUE;
		if (addr_s2_reg == OFF_BANK_POINTER) begin
			read_next = bank_pointer_reg;
		end else if (bank == BANK_PRIMARY) begin
			unique case (addr_s2_reg)
				OFF_DRIVER_OUTPUT_ENABLE:   read_next = driver_output_enable_reg;
				OFF_ALARM_SIGNAL_STATUS:    read_next = alarm_signal_status_reg;
				OFF_ALARM_INTERRUPT_MASK:   read_next = alarm_irq_mask_reg;
				OFF_ALARM_INTERRUPT_STATUS: read_next = alarm_irq_flags_reg;
				default:                    read_next = RESET_VALUE;
			endcase
		end else begin
			unique case (addr_s2_reg)
				OFF_SINGLE_RAIL_FORCE:        read_next = single_rail_force_reg;
				OFF_LINE_CODE_SELECT:         read_next = line_code_select_reg;
				OFF_RECOVERY_DISABLE:         read_next = recovery_disable_reg;
				OFF_RECEIVER_POWERDOWN:       read_next = receiver_powerdown_reg;
				OFF_TRANSMITTER_POWERDOWN:    read_next = transmitter_powerdown_reg;
				OFF_ZERO_RUN_DETECT_ENABLE:   read_next = zero_run_detect_enable_reg;
				OFF_VIOLATION_DETECT_DISABLE: read_next = violation_detect_disable_reg;
				OFF_SINGLE_ENDED_TERMINATION: read_next = single_ended_termination_reg;
				OFF_INBAND_LOOP_CONFIG:       read_next = inband_loop_config_reg;
				default:                      read_next = RESET_VALUE;
			endcase
		end
	end

	// Data is captured once at read start and driven while the read lasts
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			data_out <= RESET_VALUE;
			data_oe  <= 1'b0;
		end else begin
			data_oe <= rd_s2_reg;
			if (read_start) begin
				data_out <= read_next;
			end
		end
	end

	// Single rail when forced, else when the negative data pin is high
	assign single_next = single_rail_force_reg | tdn_s2_reg;

	// Channel control outputs
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			driver_high_z       <= '0;
			transmitter_off     <= '0;
			receiver_off        <= '0;
			single_rail_mode    <= '0;
			recovery_on         <= '1;
			ami_select          <= '0;
			zero_detect_on      <= '0;
			violation_detect_on <= '0;
			termination_single  <= '0;
		end else begin
			driver_high_z       <= driver_output_enable_reg | transmitter_powerdown_reg
			                       | clock_lost;
			transmitter_off     <= transmitter_powerdown_reg | clock_lost;
			receiver_off        <= receiver_powerdown_reg;
			single_rail_mode    <= single_next;
			recovery_on         <= ~recovery_disable_reg | single_rail_force_reg;
			ami_select          <= line_code_select_reg & single_rail_force_reg
			                       & ~recovery_disable_reg;
			zero_detect_on      <= zero_run_detect_enable_reg & single_next
			                       & ~line_code_select_reg;
			violation_detect_on <= ~violation_detect_disable_reg & single_next
			                       & ~line_code_select_reg;
			termination_single  <= single_ended_termination_reg;
		end
	end

	// Global loopback controls from the shared configuration register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			loop_detector_enable <= 1'b0;
			auto_loop_enable     <= 1'b0;
			activate_code_mask   <= code_mask(2'b00);
			deactivate_code_mask <= code_mask(2'b00);
		end else begin
			loop_detector_enable <= inband_loop_config_reg[LOOP_DET_BIT];
			auto_loop_enable     <= inband_loop_config_reg[AUTO_LOOP_BIT];
			activate_code_mask   <= code_mask(inband_loop_config_reg[ACT_LEN_LSB +: 2]);
			deactivate_code_mask <= code_mask(inband_loop_config_reg[DEACT_LEN_LSB +: 2]);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	AST_DRIVER_HIGHZ: assert property (
		##1 ((driver_high_z & $past(driver_output_enable_reg)) == $past(driver_output_enable_reg)))
		else $error("driver not high-Z with output enable bit set");

	AST_TX_CLOCK_LOW: assert property (
		##1 ((transmitter_off & $past(clock_lost | transmitter_powerdown_reg))
		     == $past(clock_lost | transmitter_powerdown_reg)))
		else $error("transmitter not off with clock low or power-down set");

	AST_STATUS_READ: assert property (
		(read_start && bank == BANK_PRIMARY && addr_s2_reg == OFF_ALARM_SIGNAL_STATUS)
		|=> (data_out == $past(alarm_signal_status_reg)))
		else $error("alarm status read returned wrong data");

	AST_MASK_BLOCKS: assert property (
		(alarm_irq_mask_reg == 8'h00 && !flag_clear) |=> $stable(alarm_irq_flags_reg))
		else $error("masked alarm change set a flag");

	AST_FLAG_SET: assert property (
		(|(alarm_edge & alarm_irq_mask_reg)) |=>
		((alarm_irq_flags_reg & $past(alarm_edge & alarm_irq_mask_reg))
		 == $past(alarm_edge & alarm_irq_mask_reg)))
		else $error("unmasked alarm change did not set its flag");

	AST_READ_CLEARS: assert property (
		(flag_clear && (alarm_edge & alarm_irq_mask_reg) == 8'h00) |=> (alarm_irq_flags_reg == 8'h00))
		else $error("alarm status read did not clear flags");

	AST_BANK_SWITCH: assert property (
		(write_commit && addr_s2_reg == OFF_BANK_POINTER && din_s2_reg == EXPANDED_KEY)
		|=> (bank == BANK_EXPANDED) [*2])
		else $error("expanded key did not select expanded bank");

	AST_POINTER_REACH: assert property (
		(write_commit && bank == BANK_EXPANDED && addr_s2_reg == OFF_BANK_POINTER)
		|=> (bank_pointer_reg == $past(din_s2_reg)))
		else $error("pointer not writable from expanded bank");

	AST_SINGLE_RAIL: assert property (
		##1 ((single_rail_mode & recovery_on & $past(single_rail_force_reg))
		     == $past(single_rail_force_reg)))
		else $error("forced single rail not applied with recovery");

	AST_AMI_GATED: assert property (
		##1 ((ami_select & ~$past(single_rail_force_reg)) == 8'h00))
		else $error("AMI selected without single rail forced");

	AST_ACT_MASK: assert property (
		##1 (activate_code_mask == code_mask($past(inband_loop_config_reg[3:2]))))
		else $error("activate code mask does not match length field");

	AST_UNMAPPED_ZERO: assert property (
		(read_start && bank == BANK_PRIMARY && addr_s2_reg == 8'h1e) |=> (data_out == 8'h00))
		else $error("unmapped offset did not read zero");

endmodule

`default_nettype wire

/* testbench/host_model.sv */
// Host processor model that drives the parallel register port
`timescale 1ns/10ps
`default_nettype none

module host_model (
	// Clock
	input  wire logic       clock,
	// Host port pins
	output logic            cs_b,
	output logic            rd_b,
	output logic            wr_b,
	output logic [7:0]      addr,
	output logic [7:0]      data_in,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe
);
	// Idle bus with strobes high
	initial begin
		cs_b = 1'b1;
		rd_b = 1'b1;
		wr_b = 1'b1;
		addr = 8'h00;
		data_in = 8'h00;
	end

	// Write: address and data settle three cycles before the strobes
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		data_in = d;
		repeat (3) @(negedge clock);
		cs_b = 1'b0;
		wr_b = 1'b0;
		repeat (5) @(negedge clock);
		cs_b = 1'b1;
		wr_b = 1'b1;
		repeat (4) @(negedge clock);
		data_in = ~d; // Released data no longer shows the last value
	endtask

	// Read: hold strobes until the device drives the bus, bounded wait
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
		int n;
		addr = a;
		ok = 1'b0;
		d = 8'hxx;
		repeat (3) @(negedge clock);
		cs_b = 1'b0;
		rd_b = 1'b0;
		for (n = 0; n < 10 && !ok; n++) begin
			@(posedge clock);
			#1;
			if (data_oe === 1'b1) begin
				ok = 1'b1;
				d = data_out;
			end
		end
		@(negedge clock);
		cs_b = 1'b1;
		rd_b = 1'b1;
		repeat (5) @(negedge clock);
	endtask
endmodule

`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the channel configuration and alarm bank
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import liu_bank_pkg::*;
	logic       clock = 1'b0;
	logic       rst_b = 1'b0;
	logic       cs_b, rd_b, wr_b, data_oe, ldet, aloop;
	logic [7:0] addr, din, dout, alarm, tclk, ntd, hz, toff, rxoff, srm, rec, ami;
	logic [7:0] zdet, vdet, term, amask, dmask, oe, m, a1, t, lost;
	logic [7:0] r [0:8];
	int         seed = 86238;
	int         n_fail = 0;
	int         check_count = 0;
	int         i;

	// 25 MHz clock
	always #20 clock = ~clock;

	host_model u_host_model (.clock(clock), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
		.addr(addr), .data_in(din), .data_out(dout), .data_oe(data_oe));

	liu_channel_config_status_bank u_liu_channel_config_status_bank (.clock(clock),
		.rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .addr(addr), .data_in(din),
		.data_out(dout), .data_oe(data_oe), .alarm_detect(alarm), .transmit_clock_pin(tclk),
		.negative_transmit_data_pin(ntd), .driver_high_z(hz), .transmitter_off(toff),
		.receiver_off(rxoff), .single_rail_mode(srm), .recovery_on(rec), .ami_select(ami),
		.zero_detect_on(zdet), .violation_detect_on(vdet), .termination_single(term),
		.loop_detector_enable(ldet), .auto_loop_enable(aloop),
		.activate_code_mask(amask), .deactivate_code_mask(dmask));

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Verdict and end of run
	task automatic end_of_test();
		$display("checks=%0d failures=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Read a register and compare; a timed-out read ends the run
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		bit         ok;
		u_host_model.read_reg(a, d, ok);
		chk(d, exp);
		if (!ok) begin
			end_of_test();
		end
	endtask

	// Effective code bits for a length field
	function automatic logic [7:0] mask_of(input logic [1:0] l);
		return 8'hff << (2'd3 - l);
	endfunction

	// Host-side code with its top bits copied into the unused low bits
	function automatic logic [7:0] fill_code(input logic [7:0] c, input logic [1:0] l);
		logic [7:0] f;
		f = c;
		for (int k = 0; k < 3 - l; k++) f[k] = c[k + 5 + l];
		return f;
	endfunction

	// Channel and loopback controls against the register image
	task automatic chk_ctl();
		logic [7:0] s;
		s = r[0] | ntd;
		chk(srm, s);
		chk(rec, ~r[2] | r[0]);
		chk(ami, r[1] & r[0] & ~r[2]);
		chk(rxoff, r[3]);
		chk(toff, r[4] | lost);
		chk(hz, oe | r[4] | lost);
		chk(zdet, r[5] & s & ~r[1]);
		chk(vdet, ~r[6] & s & ~r[1]);
		chk(term, r[7]);
		chk({6'h00, ldet, aloop}, {6'h00, r[8][5], r[8][4]});
		chk(amask, mask_of(r[8][3:2]));
		chk(dmask, mask_of(r[8][1:0]));
	endtask

	// Main sequence
	initial begin
		alarm = 8'h00;
		tclk = 8'hff;
		ntd = 8'($random(seed));
		oe = 8'h00;
		lost = 8'h00;
		for (i = 0; i < 9; i++) r[i] = 8'h00;
		repeat (8) @(negedge clock);
		rst_b = 1'b1;
		repeat (4) @(negedge clock);
		chk_ctl();
		rd_chk(OFF_BANK_POINTER, 8'h00);
		rd_chk(OFF_DRIVER_OUTPUT_ENABLE, 8'h00);
		rd_chk(8'h20, 8'h00);
		rd_chk(8'h1e, 8'h00);
		// Driver enables
		oe = 8'($random(seed));
		u_host_model.write_reg(OFF_DRIVER_OUTPUT_ENABLE, oe);
		rd_chk(OFF_DRIVER_OUTPUT_ENABLE, oe);
		chk_ctl();
		// Alarm flags: bit 1 changes while masked off
		m = (8'($random(seed)) & 8'h7c) | 8'h81;
		u_host_model.write_reg(OFF_ALARM_INTERRUPT_MASK, m);
		rd_chk(OFF_ALARM_INTERRUPT_MASK, m);
		a1 = 8'($random(seed)) | 8'h03;
		alarm = a1;
		repeat (3) @(negedge clock);
		rd_chk(OFF_ALARM_INTERRUPT_STATUS, a1 & m);
		u_host_model.write_reg(OFF_ALARM_SIGNAL_STATUS, 8'h00);
		rd_chk(OFF_ALARM_SIGNAL_STATUS, a1);
		rd_chk(OFF_ALARM_INTERRUPT_STATUS, 8'h00);
		t = 8'($random(seed)) | 8'h83;
		alarm = a1 ^ t;
		repeat (3) @(negedge clock);
		rd_chk(OFF_ALARM_INTERRUPT_STATUS, t & m);
		// Expanded bank
		u_host_model.write_reg(OFF_BANK_POINTER, EXPANDED_KEY);
		rd_chk(OFF_BANK_POINTER, EXPANDED_KEY);
		rd_chk(OFF_DRIVER_OUTPUT_ENABLE, 8'h00);
		for (i = 0; i < 9; i++) begin
			r[i] = (i == 8) ? (8'($random(seed)) & 8'h3f) : 8'($random(seed));
			u_host_model.write_reg(8'(i), r[i]);
		end
		for (i = 0; i < 9; i++) rd_chk(8'(i), r[i]);
		chk_ctl();
		// Every code length on both fields, flags walked too
		for (i = 0; i < 4; i++) begin
			r[8] = {2'b00, i[0], i[1], i[1:0], 2'(3 - i)};
			u_host_model.write_reg(OFF_INBAND_LOOP_CONFIG, r[8]);
			chk_ctl();
			chk(fill_code(a1, i[1:0]) & amask, a1 & mask_of(i[1:0]));
		end
		// Transmit clock held low on channel 3
		tclk = 8'hf7;
		lost = 8'h08;
		repeat (60) @(negedge clock);
		chk_ctl();
		u_host_model.write_reg(OFF_BANK_POINTER, PRIMARY_KEY);
		rd_chk(OFF_DRIVER_OUTPUT_ENABLE, oe);
		rd_chk(OFF_SINGLE_RAIL_FORCE, 8'h00);
		// Second reset in mid-run
		rst_b = 1'b0;
		repeat (3) @(negedge clock);
		rst_b = 1'b1;
		oe = 8'h00;
		lost = 8'h00;
		for (i = 0; i < 9; i++) r[i] = 8'h00;
		repeat (4) @(negedge clock);
		chk_ctl();
		rd_chk(OFF_BANK_POINTER, 8'h00);
		end_of_test();
	end
endmodule

`default_nettype wire
